// ===== logic/clt_line_regs.sv
`timescale 1ns/1ns
`default_nettype none
//
// How it works
// RULE1 - selected line is writable only while the enable bit 31 is one
// RULE2 - enable gates tag, mask and all four word registers alike
// RULE3 - index bits 3..0 of the access register pick the line
// RULE4 - boot bit one means region 0x1D000000, zero means 0x1FC00000
// RULE5 - hit compares the 20-bit tag at bits 23..4 with the address
// RULE6 - one tag value serves virtual and both physical flash addresses; the code matches only physical region bytes 0x1D and 0x1F
// RULE7 - only valid lines take part in hit detection
// RULE8 - locked lines are never chosen for replacement
// RULE9 - type one holds instruction words, zero holds data words
// RULE10 - unused bits read zero; software writes zero and ignores them
// RULE11 - each set mask bit forces a match at that address bit
// RULE12 - mask writes only land for lines 0x0A and 0x0B
// RULE13 - word registers read only when the part is not code protected
// RULE14 - writes while the enable bit is zero are dropped silently
// RULE15 - reset clears enable, index, valid, lock and sets type
module clt_line_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic code_protect,
   input wire clt_pkg::clt_lookup_s lookup_req,
   output logic hit_q,
   output logic [3:0] hit_line_q,
   output logic [31:0] hit_word_q,
   input wire logic fill_valid,
   input wire logic [31:0] fill_addr,
   input wire logic fill_instr,
   input wire logic [127:0] fill_words,
   output logic fill_done_q,
   output logic fill_drop_q,
   output logic [3:0] fill_line_q
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic acc_wen_q, acc_wen_d;
   logic [3:0] acc_idx_q, acc_idx_d;
   clt_pkg::clt_line_tag_s tag_q [clt_pkg::NUM_LINES];
   clt_pkg::clt_line_tag_s tag_d [clt_pkg::NUM_LINES];
   logic [10:0] mask_q [2];
   logic [10:0] mask_d [2];
   logic [31:0] word_q [clt_pkg::NUM_LINES][clt_pkg::WORDS];
   logic [31:0] word_d [clt_pkg::NUM_LINES][clt_pkg::WORDS];
   logic [3:0] rr_q, rr_d;
   logic fill_done_d, fill_drop_d;
   logic [3:0] fill_line_d;
   logic [31:0] prdata_q, prdata_d;
   logic pslverr_q, pslverr_d;
   logic hit_d;
   logic [3:0] hit_line_d;
   logic [31:0] hit_word_d;
   logic [10:0] line_mask [clt_pkg::NUM_LINES];
   logic hit_now, victim_ok;
   logic [3:0] hit_idx, victim_idx;
   logic setup, wr_fire, known, mask_line, word_addr;
   logic [1:0] word_sel;
   logic [7:0] fill_hi;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   // reads are sampled in setup, writes land at the access edge
   assign setup = psel && !penable;
   assign wr_fire = psel && penable && pwrite;
   assign word_addr = (paddr >= clt_pkg::OFS_W0) && (paddr <= clt_pkg::OFS_W3) && (paddr[1:0] == 2'h0);
   assign known = word_addr || (paddr == clt_pkg::OFS_ACC) || (paddr == clt_pkg::OFS_TAG)
      || (paddr == clt_pkg::OFS_MSK);
   assign word_sel = 2'((paddr - clt_pkg::OFS_W0) >> 2);
   assign mask_line = (acc_idx_q == clt_pkg::MASK_LINE_A) || (acc_idx_q == clt_pkg::MASK_LINE_B);
   assign pready = psel && penable; // zero wait states
   assign prdata = prdata_q;
   assign pslverr = pslverr_q && psel && penable;
   assign fill_hi = fill_addr[31:24];

   // mask only exists for the two maskable lines
   always_comb begin
      for (int i = 0; i < clt_pkg::NUM_LINES; i++) begin
         line_mask[i] = 11'h000; // other lines never mask [RULE12]
      end
      line_mask[clt_pkg::MASK_LINE_A] = mask_q[0]; // [RULE11]
      line_mask[clt_pkg::MASK_LINE_B] = mask_q[1];
   end

   // ----------------------------------------
   // lookup and replacement helpers
   // ----------------------------------------
   clt_hit_find u_hit (
      .tags(tag_q),
      .masks(line_mask),
      .req(lookup_req),
      .hit(hit_now),
      .idx(hit_idx)
   );

   clt_victim_pick u_victim (
      .tags(tag_q),
      .rr(rr_q),
      .found(victim_ok),
      .idx(victim_idx)
   );

   // ----------------------------------------
   // register file and line store
   // ----------------------------------------
   // software writes win over a fill aimed at the same line
   always_comb begin
      logic sw_line_hit;
      sw_line_hit = 1'b0;
      acc_wen_d = acc_wen_q;
      acc_idx_d = acc_idx_q;
      tag_d = tag_q;
      mask_d = mask_q;
      word_d = word_q;
      rr_d = rr_q;
      fill_done_d = 1'b0;
      fill_drop_d = 1'b0;
      fill_line_d = fill_line_q;
      if (wr_fire && paddr == clt_pkg::OFS_ACC) begin
         acc_wen_d = pwdata[clt_pkg::WEN_BIT]; // [RULE1]
         acc_idx_d = pwdata[3:0]; // [RULE3]
      end
      // gated by the enable; a write with it clear is dropped [RULE14]
      if (wr_fire && acc_wen_q) begin
         if (paddr == clt_pkg::OFS_TAG) begin
            sw_line_hit = 1'b1;
            // reserved bits are not stored [RULE10]
            tag_d[acc_idx_q].boot = pwdata[clt_pkg::BOOT_BIT]; // [RULE2]
            tag_d[acc_idx_q].tag = pwdata[23:4]; // [RULE5]
            tag_d[acc_idx_q].valid = pwdata[clt_pkg::VALID_BIT];
            tag_d[acc_idx_q].lock = pwdata[clt_pkg::LOCK_BIT];
            tag_d[acc_idx_q].itype = pwdata[clt_pkg::TYPE_BIT]; // [RULE9]
         end
         if (paddr == clt_pkg::OFS_MSK && mask_line) begin
            mask_d[acc_idx_q[0]] = pwdata[15:5]; // [RULE12] [RULE2]
         end
         if (word_addr) begin
            sw_line_hit = 1'b1;
            word_d[acc_idx_q][word_sel] = pwdata; // [RULE2]
         end
      end
      // a miss fill goes to an unlocked victim in either flash region
      if (fill_valid) begin
         fill_line_d = victim_idx;
         if (victim_ok && !(sw_line_hit && victim_idx == acc_idx_q)
            && (fill_hi == clt_pkg::BOOT_REGION_HI || fill_hi == clt_pkg::OTHER_REGION_HI)) begin
            fill_done_d = 1'b1;
            rr_d = victim_idx + 4'h1;
            tag_d[victim_idx].boot = (fill_hi == clt_pkg::BOOT_REGION_HI); // [RULE4]
            tag_d[victim_idx].tag = fill_addr[23:4];
            tag_d[victim_idx].valid = 1'b1;
            tag_d[victim_idx].lock = 1'b0; // [RULE8]
            tag_d[victim_idx].itype = fill_instr; // [RULE9]
            for (int w = 0; w < clt_pkg::WORDS; w++) begin
               word_d[victim_idx][w] = fill_words[w*32 +: 32];
            end
         end else begin
            fill_drop_d = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_wen_q <= 1'b0; // [RULE15]
         acc_idx_q <= 4'h0;
         for (int i = 0; i < clt_pkg::NUM_LINES; i++) begin
            tag_q[i] <= '{boot: 1'b0, tag: 20'h0_0000, valid: clt_pkg::RST_VALID,
               lock: clt_pkg::RST_LOCK, itype: clt_pkg::RST_TYPE}; // [RULE15]
            for (int w = 0; w < clt_pkg::WORDS; w++) begin
               word_q[i][w] <= clt_pkg::RST_WORD;
            end
         end
         mask_q[0] <= 11'h000;
         mask_q[1] <= 11'h000;
         rr_q <= 4'h0;
         fill_done_q <= 1'b0;
         fill_drop_q <= 1'b0;
         fill_line_q <= 4'h0;
      end else begin
         acc_wen_q <= acc_wen_d;
         acc_idx_q <= acc_idx_d;
         tag_q <= tag_d;
         mask_q <= mask_d;
         word_q <= word_d;
         rr_q <= rr_d;
         fill_done_q <= fill_done_d;
         fill_drop_q <= fill_drop_d;
         fill_line_q <= fill_line_d;
      end
   end

   // ----------------------------------------
   // read answer
   // ----------------------------------------
   // captured at setup so the access phase needs no wait state
   always_comb begin
      prdata_d = prdata_q;
      pslverr_d = pslverr_q;
      if (setup) begin
         pslverr_d = !known;
         prdata_d = 32'h0000_0000; // unmapped and reserved read zero [RULE10]
         if (paddr == clt_pkg::OFS_ACC) begin
            prdata_d = {acc_wen_q, 27'h000_0000, acc_idx_q}; // [RULE10]
         end else if (paddr == clt_pkg::OFS_TAG) begin
            prdata_d = clt_pkg::clt_tag_word(tag_q[acc_idx_q]); // [RULE3]
         end else if (paddr == clt_pkg::OFS_MSK) begin
            prdata_d = {16'h0000, line_mask[acc_idx_q], 5'h00};
         end else if (word_addr && !code_protect) begin
            prdata_d = word_q[acc_idx_q][word_sel]; // [RULE13]
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q <= prdata_d;
         pslverr_q <= pslverr_d;
      end
   end

   // ----------------------------------------
   // lookup result
   // ----------------------------------------
   // one cycle after the request, word picked by address bits 3..2
   always_comb begin
      hit_d = hit_now; // [RULE7]
      hit_line_d = hit_idx;
      hit_word_d = hit_now ? word_q[hit_idx][lookup_req.addr[3:2]] : 32'h0000_0000;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hit_q <= 1'b0;
         hit_line_q <= 4'h0;
         hit_word_q <= 32'h0000_0000;
      end else begin
         hit_q <= hit_d;
         hit_line_q <= hit_line_d;
         hit_word_q <= hit_word_d;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [31:0] sel_tag_word;
   logic any_valid;
   assign sel_tag_word = clt_pkg::clt_tag_word(tag_q[acc_idx_q]);
   always_comb begin
      any_valid = 1'b0;
      for (int i = 0; i < clt_pkg::NUM_LINES; i++) begin
         any_valid = any_valid | tag_q[i].valid;
      end
   end

   sequence s_tag_wr;
      wr_fire && paddr == clt_pkg::OFS_TAG && !fill_valid;
   endsequence
   sequence s_word_rd;
      setup && !pwrite && word_addr;
   endsequence
   // fill aimed outside both flash regions
   sequence s_fill_off_region;
      fill_valid && fill_hi != clt_pkg::BOOT_REGION_HI && fill_hi != clt_pkg::OTHER_REGION_HI;
   endsequence

   AST_TAG_LOCKED_OUT: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
      s_tag_wr and !acc_wen_q |=> sel_tag_word == $past(sel_tag_word))
      else $error("tag changed while line writes disabled");
   AST_TAG_WRITE_LANDS: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
      s_tag_wr and acc_wen_q |=> sel_tag_word == ($past(pwdata) & 32'h80ff_fffe))
      else $error("enabled tag write not stored");
   AST_WORD_LOCKED_OUT: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
      wr_fire && paddr == clt_pkg::OFS_W0 && !acc_wen_q && !fill_valid
      |=> word_q[acc_idx_q][0] == $past(word_q[acc_idx_q][0]))
      else $error("word changed while line writes disabled");
   AST_MASK_LINES_ONLY: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
      wr_fire && paddr == clt_pkg::OFS_MSK && !mask_line |=> $stable(mask_q[0]) && $stable(mask_q[1]))
      else $error("mask written for a line without mask");
   AST_INDEX_SELECT: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
      wr_fire && paddr == clt_pkg::OFS_ACC |=> acc_idx_q == $past(pwdata[3:0]) && acc_wen_q == $past(pwdata[31]))
      else $error("access register did not take the write");
   AST_PROTECT_READ: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
      s_word_rd and code_protect |=> prdata == 32'h0000_0000 ##0 pready)
      else $error("word readable while protected");
   AST_ACC_RESERVED: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
      setup && !pwrite && paddr == clt_pkg::OFS_ACC |=> prdata[30:4] == 27'h000_0000)
      else $error("reserved access bits not zero");
   AST_NO_VALID_NO_HIT: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
      lookup_req.valid && !any_valid |=> !hit_q)
      else $error("hit reported with no valid line");
   AST_HIT_REGION: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
      hit_q |-> $past(lookup_req.addr[31:24]) == clt_pkg::clt_region($past(tag_q[hit_idx].boot)))
      else $error("hit outside the line region");
   AST_VICTIM_UNLOCKED: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
      fill_done_q |-> !$past(tag_q[victim_idx].lock))
      else $error("locked line replaced");

   // a hit must come from a valid line of the asked type
   AST_HIT_VALID: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
      hit_q |-> $past(tag_q[hit_idx].valid))
      else $error("hit reported from an invalid line");
   AST_HIT_TYPE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
      hit_q |-> $past(tag_q[hit_idx].itype) == $past(lookup_req.instr))
      else $error("hit on a line of the other type");

   // fill outcome and the line it leaves behind
   AST_FILL_REGION: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
      s_fill_off_region |=> fill_drop_q && !fill_done_q)
      else $error("fill outside flash regions accepted");
   AST_FILL_STORED: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
      fill_done_q |-> tag_q[fill_line_q].valid && !tag_q[fill_line_q].lock
         && tag_q[fill_line_q].boot == ($past(fill_hi) == clt_pkg::BOOT_REGION_HI))
      else $error("filled line tag fields wrong");

   // register side: gating, reserved bits and the lines without a mask
   AST_WORD_WRITE_LANDS: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
      wr_fire && word_addr && acc_wen_q && !fill_valid |=> word_q[acc_idx_q][$past(word_sel)] == $past(pwdata))
      else $error("enabled word write not stored");
   AST_MASK_NEEDS_WEN: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
      wr_fire && paddr == clt_pkg::OFS_MSK && !acc_wen_q |=> $stable(mask_q[0]) && $stable(mask_q[1]))
      else $error("mask written while line writes disabled");
   AST_MASK_READ_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
      setup && !pwrite && paddr == clt_pkg::OFS_MSK && !mask_line |=> prdata == 32'h0000_0000)
      else $error("mask read nonzero for a line without mask");
   AST_TAG_RESERVED: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
      setup && !pwrite && paddr == clt_pkg::OFS_TAG |=> prdata[30:24] == 7'h00 && !prdata[0])
      else $error("reserved tag bits not zero");
endmodule : clt_line_regs
`default_nettype wire

// ===== logic/clt_pkg.sv
`default_nettype none
package clt_pkg;
   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int unsigned NUM_LINES = 16;
   localparam int unsigned WORDS = 4;
   localparam logic [3:0] MASK_LINE_A = 4'ha;
   localparam logic [3:0] MASK_LINE_B = 4'hb;
   // ----------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] OFS_ACC = 8'h00;
   localparam logic [7:0] OFS_TAG = 8'h04;
   localparam logic [7:0] OFS_MSK = 8'h08;
   localparam logic [7:0] OFS_W0 = 8'h0c;
   localparam logic [7:0] OFS_W3 = 8'h18;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int unsigned WEN_BIT = 31;
   localparam int unsigned BOOT_BIT = 31;
   localparam int unsigned VALID_BIT = 3;
   localparam int unsigned LOCK_BIT = 2;
   localparam int unsigned TYPE_BIT = 1;
   localparam int unsigned MASK_LSB = 5;
   localparam logic [7:0] BOOT_REGION_HI = 8'h1d;
   localparam logic [7:0] OTHER_REGION_HI = 8'h1f;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic RST_VALID = 1'h0;
   localparam logic RST_LOCK = 1'h0;
   localparam logic RST_TYPE = 1'h1;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   typedef struct packed {
      logic boot;
      logic [19:0] tag;
      logic valid;
      logic lock;
      logic itype;
   } clt_line_tag_s;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic instr;
   } clt_lookup_s;

   // tag register image; reserved bits read as zero
   function automatic logic [31:0] clt_tag_word(clt_line_tag_s t);
      return {t.boot, 7'h00, t.tag, t.valid, t.lock, t.itype, 1'h0};
   endfunction : clt_tag_word

   // region byte of a line, boot-area bit chooses the region
   function automatic logic [7:0] clt_region(logic boot);
      return boot ? BOOT_REGION_HI : OTHER_REGION_HI;
   endfunction : clt_region

   // tag compare; mask bit k forces address bit k+5
   function automatic logic clt_tag_match(clt_line_tag_s t, logic [10:0] m, logic [31:0] a);
      logic [19:0] force_m;
      force_m = {8'h00, m, 1'h0};
      return t.valid && (a[31:24] == clt_region(t.boot)) && (((a[23:4] ^ t.tag) & ~force_m) == 20'h0_0000);
   endfunction : clt_tag_match
endpackage : clt_pkg
`default_nettype wire

// ===== logic/clt_hit_find.sv
`timescale 1ns/1ns
`default_nettype none
module clt_hit_find (
   input wire clt_pkg::clt_line_tag_s tags [clt_pkg::NUM_LINES],
   input wire logic [10:0] masks [clt_pkg::NUM_LINES],
   input wire clt_pkg::clt_lookup_s req,
   output logic hit,
   output logic [3:0] idx
);
   // ----------------------------------------
   // parallel compare, lowest line wins
   // ----------------------------------------
   always_comb begin
      hit = 1'b0;
      idx = 4'h0;
      for (int i = clt_pkg::NUM_LINES - 1; i >= 0; i--) begin
         // tag matches only the physical region byte chosen by the boot bit, so virtual flash views miss [RULE6]
         if (req.valid && (tags[i].itype == req.instr) && clt_pkg::clt_tag_match(tags[i], masks[i], req.addr)) begin
            hit = 1'b1;
            idx = 4'(i);
         end
      end
   end
endmodule : clt_hit_find
`default_nettype wire

// ===== logic/clt_victim_pick.sv
`timescale 1ns/1ns
`default_nettype none
module clt_victim_pick (
   input wire clt_pkg::clt_line_tag_s tags [clt_pkg::NUM_LINES],
   input wire logic [3:0] rr,
   output logic found,
   output logic [3:0] idx
);
   // ----------------------------------------
   // victim choice
   // ----------------------------------------
   // free unlocked lines first, then round robin from rr
   always_comb begin
      logic [3:0] j;
      logic got_free;
      j = 4'h0;
      got_free = 1'b0;
      found = 1'b0;
      idx = 4'h0;
      for (int k = clt_pkg::NUM_LINES - 1; k >= 0; k--) begin
         j = rr + 4'(k);
         if (!tags[j].lock) begin // locked lines are never taken [RULE8]
            found = 1'b1;
            idx = j;
         end
      end
      for (int k = clt_pkg::NUM_LINES - 1; k >= 0; k--) begin
         if (!tags[k].lock && !tags[k].valid) begin
            got_free = 1'b1;
         end
      end
      if (got_free) begin
         for (int k = clt_pkg::NUM_LINES - 1; k >= 0; k--) begin
            if (!tags[k].lock && !tags[k].valid) begin
               idx = 4'(k);
            end
         end
      end
   end
endmodule : clt_victim_pick
`default_nettype wire

// ===== tb/clt_line_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module clt_line_regs_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic code_protect = 1'b0;
   clt_pkg::clt_lookup_s lookup_req = '0;
   logic fill_valid = 1'b0;
   logic [31:0] fill_addr = 32'h0000_0000;
   logic fill_instr = 1'b0;
   logic [127:0] fill_words = '0;
   logic [31:0] prdata, hit_word_q;
   logic pready, pslverr, hit_q, fill_done_q, fill_drop_q;
   logic [3:0] hit_line_q, fill_line_q;
   int n_errors = 0;
   int total_checks = 0;
   // bench mirror of the register file
   logic [31:0] m_acc;
   logic [31:0] m_tag [16];
   logic [31:0] m_msk [16];
   logic [31:0] m_w [16][4];

   clt_line_regs clt_line_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .code_protect(code_protect), .lookup_req(lookup_req), .hit_q(hit_q), .hit_line_q(hit_line_q),
      .hit_word_q(hit_word_q), .fill_valid(fill_valid), .fill_addr(fill_addr), .fill_instr(fill_instr),
      .fill_words(fill_words), .fill_done_q(fill_done_q), .fill_drop_q(fill_drop_q), .fill_line_q(fill_line_q));

   // ----------------------------------------
   // clock and helpers
   // ----------------------------------------
   always #20 pclk = ~pclk;

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", nm, exp, got);
         n_errors++;
      end
   endtask : chk

   task automatic final_report;
      if (n_errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report

   function automatic logic mapped(input logic [7:0] a);
      return a <= 8'h18 && a[1:0] == 2'h0;
   endfunction : mapped

   // bits software may set in the tag, mask and word registers; unused ones are written zero
   function automatic logic [31:0] legal_bits(input logic [7:0] a);
      if (a == 8'h04) return 32'h80ff_fffe;
      if (a == 8'h08) return 32'h0000_ffe0;
      return 32'hffff_ffff;
   endfunction : legal_bits

   function automatic logic [31:0] exp_rd(input logic [7:0] a);
      if (!mapped(a)) return 32'h0000_0000;
      if (a == 8'h00) return m_acc;
      if (a == 8'h04) return m_tag[m_acc[3:0]];
      if (a == 8'h08) return m_msk[m_acc[3:0]];
      return code_protect ? 32'h0000_0000 : m_w[m_acc[3:0]][(a - 8'h0c) >> 2];
   endfunction : exp_rd

   // one apb transfer; waits for pready under a bound, ends one idle edge later
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) chk("pready", 32'h1, 32'h0);
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic er;
      logic [3:0] i;
      apb(1'b1, a, d, rd, er);
      chk("write pslverr", {31'h0, !mapped(a)}, {31'h0, er});
      i = m_acc[3:0];
      if (a == 8'h00) m_acc = d & 32'h8000_000f;
      else if (a == 8'h04 && m_acc[31]) m_tag[i] = d & 32'h80ff_fffe;
      else if (a == 8'h08 && m_acc[31] && (i == clt_pkg::MASK_LINE_A || i == clt_pkg::MASK_LINE_B))
         m_msk[i] = d & 32'h0000_ffe0;
      else if (mapped(a) && a >= 8'h0c && m_acc[31]) m_w[i][(a - 8'h0c) >> 2] = d;
   endtask : wr

   task automatic rdc(input logic [7:0] a);
      logic [31:0] rd;
      logic er;
      apb(1'b0, a, 32'h0000_0000, rd, er);
      chk("read data", exp_rd(a), rd);
      chk("read pslverr", {31'h0, !mapped(a)}, {31'h0, er});
   endtask : rdc

   // lookup: expectation searches the mirror, lowest line wins
   task automatic lk(input logic [31:0] a, input logic ins);
      logic eh;
      logic [3:0] el;
      logic [31:0] t, ew;
      eh = 1'b0;
      el = 4'h0;
      ew = 32'h0;
      for (int i = 15; i >= 0; i--) begin
         t = m_tag[i];
         if (t[3] && t[1] == ins && a[31:24] == (t[31] ? 8'h1d : 8'h1f) &&
             ((a[23:4] ^ t[23:4]) & ~{8'h00, m_msk[i][15:5], 1'b0}) == 20'h0_0000) begin
            eh = 1'b1;
            el = 4'(i);
            ew = m_w[i][a[3:2]];
         end
      end
      lookup_req <= '{valid: 1'b1, addr: a, instr: ins};
      @(posedge pclk);
      lookup_req <= '0;
      #1;
      chk("hit_q", {31'h0, eh}, {31'h0, hit_q});
      if (eh) chk("hit_line_q", {28'h0, el}, {28'h0, hit_line_q});
      if (eh) chk("hit_word_q", ew, hit_word_q);
      @(posedge pclk);
   endtask : lk

   task automatic fl(input logic [31:0] a, input logic ins, input logic ed, input logic [3:0] el);
      logic [127:0] w;
      w = {$urandom, $urandom, $urandom, $urandom};
      fill_valid <= 1'b1;
      fill_addr <= a;
      fill_instr <= ins;
      fill_words <= w;
      @(posedge pclk);
      fill_valid <= 1'b0;
      #1;
      chk("fill_done_q", {31'h0, ed}, {31'h0, fill_done_q});
      chk("fill_drop_q", {31'h0, !ed}, {31'h0, fill_drop_q});
      if (ed) chk("fill_line_q", {28'h0, el}, {28'h0, fill_line_q});
      if (ed) m_tag[el] = {a[31:24] == 8'h1d, 7'h00, a[23:4], 1'b1, 1'b0, ins, 1'b0};
      for (int k = 0; k < 4; k++) if (ed) m_w[el][k] = w[32*k +: 32];
      @(posedge pclk);
   endtask : fl

   // ----------------------------------------
   // directed corners, then random traffic
   // ----------------------------------------
   initial begin
      logic [31:0] t, a;
      int i;
      void'($urandom(32'h6116f053));
      m_acc = 32'h0;
      for (int j = 0; j < 16; j++) begin
         m_tag[j] = 32'h0000_0002;
         m_msk[j] = 32'h0;
         for (int k = 0; k < 4; k++) m_w[j][k] = 32'h0;
      end
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int j = 0; j < 9; j++) rdc(8'(4 * j));
      rdc(8'h40);
      wr(8'h04, 32'h80ff_fffa);
      rdc(8'h04);
      for (int j = 9; j < 12; j++) begin
         wr(8'h00, 32'h8000_0000 | j);
         wr(8'h08, 32'h0000_ffe0);
         rdc(8'h08);
      end
      // locked invalid line 0 must be skipped as victim
      wr(8'h00, 32'h8000_0000);
      wr(8'h04, 32'h0000_0004);
      fl(32'h1d01_2340, 1'b1, 1'b1, 4'h1);
      fl(32'h2000_0000, 1'b0, 1'b0, 4'h0);
      for (int j = 0; j < 16; j++) begin
         wr(8'h00, 32'h8000_0000 | j);
         wr(8'h04, 32'h0000_0004);
      end
      fl(32'h1fc0_0100, 1'b0, 1'b0, 4'h0);
      // masked line: bit 5 masked, bit 4 not; type and region must match
      wr(8'h00, 32'h8000_000a);
      wr(8'h04, 32'h8012_345a);
      lk(32'h1d12_3454, 1'b1);
      lk(32'h1d12_3474, 1'b1);
      lk(32'h1d12_3444, 1'b1);
      lk(32'h1d12_3454, 1'b0);
      lk(32'h1f12_3454, 1'b1);
      wr(8'h04, 32'h8012_3452);
      lk(32'h1d12_3454, 1'b1);
      for (int n = 0; n < 500; n++) begin
         i = $urandom % 4;
         if (i == 0) wr(8'h00, ($urandom & 32'h0000_000f) | (($urandom % 4 != 0) << 31));
         else if (i == 1) begin
            a = 32'(4 + 4 * ($urandom % 6));
            wr(a[7:0], $urandom & legal_bits(a[7:0]));
         end else if (i == 2) begin
            code_protect <= 1'($urandom);
            rdc(8'(4 * ($urandom % 8)));
         end else begin
            t = m_tag[$urandom % 16];
            a = {t[31] ? 8'h1d : 8'h1f, t[23:4], 4'($urandom)};
            if ($urandom % 2) a = a ^ (32'h1 << ($urandom % 24));
            lk(a, ($urandom % 4 != 0) ? t[1] : 1'($urandom));
         end
      end
      final_report();
   end

   // hang guard, well beyond the expected run length
   initial begin
      #(40 * 20000);
      n_errors++;
      final_report();
   end
endmodule : clt_line_regs_tb_top
`default_nettype wire
